// >>> motor_pkg.sv
/*
  constants shared by both ends of the paper feed and carriage motor link:
  clock rate, step and decay timing, register map, phase codes, states.
  assumes a single 40 MHz logic clock on both ends.
*/
package motor_pkg;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int STEP_TIME_US = 2000;
    localparam int STEP_CYCLES = STEP_TIME_US * (CLK_HZ / 1_000_000);
    localparam int DECAY_TIME_US = 100;
    localparam int DECAY_CYCLES = DECAY_TIME_US * (CLK_HZ / 1_000_000);
    localparam int STEPS_PER_LINE = 12;
    // ==========================================================
    // register map, byte addresses of aligned 32-bit words
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_FEED = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int CTRL_CARR_ON = 0;
    localparam int CTRL_CARR_HIGH = 1;
    localparam int CTRL_CARR_REV = 2;
    localparam int CTRL_FEED_REV = 3;
    localparam int FEED_LINES_LSB = 0;
    localparam int FEED_ALIGN_BIT = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PHASE_LSB = 4;
    localparam int STAT_LEFT_LSB = 8;
    localparam int LEFT_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // active-low phase selects, bit 0 = A, bit 1 = B, bit 2 = C
    localparam logic [2:0] PHASE_A_N = 3'h6;
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_STEP = 2'h1,
        ST_LAST = 2'h3
    } feed_state_type;
endpackage

// >>> motor_link_if.sv
/*
  control lines from the processor board to the motor driver board.
  assumes both ends run on the same clock; all lines are active low.
*/
`timescale 1ns/1ps
`default_nettype none
interface motor_link_if;
    logic [2:0] phase_sel_n;
    logic step_current_sel_n;
    logic fast_decay_n;
    logic carriage_dir_fwd_n;
    logic carriage_current_on_n;
    logic carriage_high_current_n;
    // ==========================================================
    // processor side drives, driver side listens
    modport ctrl (
        output phase_sel_n, step_current_sel_n, fast_decay_n,
        output carriage_dir_fwd_n, carriage_current_on_n, carriage_high_current_n
    );
    modport drv (
        input phase_sel_n, step_current_sel_n, fast_decay_n,
        input carriage_dir_fwd_n, carriage_current_on_n, carriage_high_current_n
    );
endinterface
`default_nettype wire

// >>> step_timer.sv
/*
  free-running step interval counter with a fast decay window marker.
  assumes restart_i comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
    parameter int unsigned STEP_CYCLES = motor_pkg::STEP_CYCLES,
    parameter int unsigned DECAY_CYCLES = motor_pkg::DECAY_CYCLES
) (
    input wire logic clk_i, // logic clock
    input wire logic rst_i, // async reset, high
    input wire logic restart_i, // start a new interval
    output logic step_done_o, // last cycle of interval
    output logic decay_end_o // last cycle of decay window
);
    import motor_pkg::*;
    localparam int unsigned CNT_W = $clog2(STEP_CYCLES);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;

    // ==========================================================
    // counter wraps on its own so steps follow without a gap
    assign step_done_o = (count_reg == CNT_W'(STEP_CYCLES - 1));
    assign decay_end_o = (count_reg == CNT_W'(DECAY_CYCLES - 1));

    always_comb begin
        count_next = count_reg + 1'b1;
        if (restart_i || step_done_o) begin
            count_next = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// >>> motor_controller.sv
/*
  processor-board end: AXI4-Lite register slave that sequences the
  three-phase paper feed stepper and sets the carriage motor lines.
  assumes the driver board listens on the motor_link_if drv modport and
  that the bus master shares clk_i.
*/
// What this block does
// R1 - forward order A,B,C; reverse order C,B,A
// R2 - exactly one phase select low always
// R3 - step select low gives 3.0A, high 1.0A
// R4 - fast decay low selects fast decay path
// R5 - power-on selects phase A at hold current
// R6 - form align moves hold to next phase
// R7 - fast decay stays high while holding/regulating
// R8 - chop phase current between comparator limits
// R9 - fast decay low at each normal step end
// R10 - each phase energized 2 ms when stepping
// R11 - final detent step keeps slow decay
// R12 - one line feed is 12 steps
// R13 - after sequence, hold last phase at 1A
// R14 - direction high swaps to reverse pair
// R15 - carriage reference 2.86A or 1.43A
// R16 - no motor power without power good
// R17 - carriage current-on low enables current
// R18 - carriage high-current low selects high level
// R19 - carriage direction low is forward
// R20 - step timed by clock; lines change on steps
`timescale 1ns/1ps
`default_nettype none
module motor_controller #(
    parameter int unsigned STEP_CYCLES = motor_pkg::STEP_CYCLES  // 2 ms step
) (
    input wire logic clk_i, // 40 MHz
    input wire logic rst_i, // async reset, high
    input wire logic s_axi_awvalid_i, // write address valid
    output logic s_axi_awready_o, // write address ready
    input wire logic [motor_pkg::ADDR_W-1:0] s_axi_awaddr_i, // write address
    input wire logic s_axi_wvalid_i, // write data valid
    output logic s_axi_wready_o, // write data ready
    input wire logic [motor_pkg::DATA_W-1:0] s_axi_wdata_i, // write data
    input wire logic [3:0] s_axi_wstrb_i, // byte strobes
    output logic s_axi_bvalid_o, // write response valid
    input wire logic s_axi_bready_i, // write response ready
    output logic [1:0] s_axi_bresp_o, // write response
    input wire logic s_axi_arvalid_i, // read address valid
    output logic s_axi_arready_o, // read address ready
    input wire logic [motor_pkg::ADDR_W-1:0] s_axi_araddr_i, // read address
    output logic s_axi_rvalid_o, // read data valid
    input wire logic s_axi_rready_i, // read data ready
    output logic [motor_pkg::DATA_W-1:0] s_axi_rdata_o, // read data
    output logic [1:0] s_axi_rresp_o, // read response
    motor_link_if.ctrl link // lines to driver
);
    import motor_pkg::*;
    // ==========================================================
    // phase rotation
    // an illegal pattern falls back to phase A so one winding stays on
    function automatic logic [2:0] next_phase(input logic [2:0] cur_n, input logic rev);
        logic [2:0] res;
        res = rev ? {cur_n[0], cur_n[2:1]} : {cur_n[1:0], cur_n[2]}; // R1
        if (cur_n != 3'h6 && cur_n != 3'h5 && cur_n != 3'h3) begin
            res = PHASE_A_N; // R2
        end
        return res;
    endfunction
    // ==========================================================
    // bus slave state
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [2:0] carr_n_reg, carr_n_next;
    logic feed_go, align_go;
    // feed sequencer state
    feed_state_type state_reg, state_next;
    logic [2:0] phase_n_reg, phase_n_next;
    logic cur_n_reg, cur_n_next, fast_n_reg, fast_n_next;
    logic [LEFT_W-1:0] left_reg, left_next;
    logic restart, step_done, decay_end;
    logic [7:0] lines;
    assign lines = wdata_reg[FEED_LINES_LSB +: 8];
    // ==========================================================
    // write and read channels; a write acts the cycle after both halves are held
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready_i;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready_i;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        feed_go = 1'b0;
        align_go = 1'b0;
        if (s_axi_awvalid_i && awready_reg) begin
            aw_held_next = 1'b1;
            awaddr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata_i;
            wstrb_next = s_axi_wstrb_i;
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            unique case (awaddr_reg)
                ADDR_CTRL: ctrl_next = wstrb_reg[0] ? wdata_reg[CTRL_W-1:0] : ctrl_reg;
                ADDR_FEED: begin
                    feed_go = wstrb_reg[0] && (lines != 8'h00);
                    align_go = wstrb_reg[1] && wdata_reg[FEED_ALIGN_BIT];
                end
                ADDR_STATUS: begin end
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
        if (s_axi_arvalid_i && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            unique case (s_axi_araddr_i)
                ADDR_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
                ADDR_FEED: rdata_next = '0;
                ADDR_STATUS: begin
                    rdata_next[STAT_BUSY] = (state_reg != ST_HOLD);
                    rdata_next[STAT_PHASE_LSB +: 3] = phase_n_reg;
                    rdata_next[STAT_LEFT_LSB +: LEFT_W] = left_reg;
                end
                default: rresp_next = RESP_SLVERR;
            endcase
        end
        arready_next = !rvalid_next;
        // carriage on and high lines are active low copies of their control bits; forward-low line copies the reverse bit
        carr_n_next[0] = !ctrl_next[CTRL_CARR_ON]; // R17
        carr_n_next[1] = !ctrl_next[CTRL_CARR_HIGH]; // R18
        carr_n_next[2] = ctrl_next[CTRL_CARR_REV]; // R19
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            ctrl_reg <= CTRL_RESET;
            carr_n_reg <= 3'h3;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            carr_n_reg <= carr_n_next;
        end
    end
    // ==========================================================
    // step interval timer
    step_timer #(.STEP_CYCLES(STEP_CYCLES), .DECAY_CYCLES(DECAY_CYCLES)) i_step_timer (.clk_i(clk_i),
        .rst_i(rst_i), .restart_i(restart), .step_done_o(step_done), .decay_end_o(decay_end));
    // ==========================================================
    // feed sequencer; requests while busy are dropped, not queued
    always_comb begin
        state_next = state_reg;
        phase_n_next = phase_n_reg;
        cur_n_next = cur_n_reg;
        fast_n_next = fast_n_reg;
        left_next = left_reg;
        restart = 1'b0;
        unique case (state_reg)
            ST_HOLD: begin
                if (feed_go) begin
                    phase_n_next = next_phase(phase_n_reg, ctrl_reg[CTRL_FEED_REV]); // R1
                    cur_n_next = 1'b0;
                    fast_n_next = 1'b0; // R9
                    left_next = LEFT_W'({4'h0, lines} * LEFT_W'(STEPS_PER_LINE) - LEFT_W'(1)); // R12
                    restart = 1'b1; // R20
                    state_next = ST_STEP;
                end else if (align_go) begin
                    phase_n_next = next_phase(phase_n_reg, ctrl_reg[CTRL_FEED_REV]); // R6
                end
            end
            ST_STEP: begin
                if (decay_end) begin
                    fast_n_next = 1'b1; // R7
                end
                if (step_done) begin // R10
                    phase_n_next = next_phase(phase_n_reg, ctrl_reg[CTRL_FEED_REV]); // R1
                    left_next = left_reg - LEFT_W'(1);
                    if (left_reg == LEFT_W'(1)) begin
                        fast_n_next = 1'b1; // R11
                        state_next = ST_LAST;
                    end else begin
                        fast_n_next = 1'b0; // R9
                    end
                end
            end
            ST_LAST: begin
                if (step_done) begin
                    cur_n_next = 1'b1; // R13
                    state_next = ST_HOLD;
                end
            end
        endcase
    end
    // reset leaves phase A held at the low current
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_HOLD;
            phase_n_reg <= PHASE_A_N; // R5
            cur_n_reg <= 1'b1;
            fast_n_reg <= 1'b1;
            left_reg <= '0;
        end else begin
            state_reg <= state_next;
            phase_n_reg <= phase_n_next;
            cur_n_reg <= cur_n_next;
            fast_n_reg <= fast_n_next;
            left_reg <= left_next;
        end
    end
    // ==========================================================
    // outputs straight from flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign link.phase_sel_n = phase_n_reg; // R2
    assign link.step_current_sel_n = cur_n_reg;
    assign link.fast_decay_n = fast_n_reg;
    assign link.carriage_current_on_n = carr_n_reg[0];
    assign link.carriage_high_current_n = carr_n_reg[1];
    assign link.carriage_dir_fwd_n = carr_n_reg[2];
endmodule
`default_nettype wire

// >>> motor_driver.sv
/*
  driver-board end: turns the active-low control lines into power switch
  commands, chopping phase and carriage current between comparator limits.
  assumes comparator outputs and power good arrive as asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
module motor_driver (
    input wire logic clk_i, // 40 MHz
    input wire logic rst_i, // async reset, high
    motor_link_if.drv link, // lines from processor
    input wire logic power_good_i, // supplies good, pin
    input wire logic [2:0] phase_at_upper_i, // phase current at upper limit
    input wire logic [2:0] phase_at_lower_i, // phase current at lower limit
    input wire logic carr_at_upper_i, // carriage current at upper limit
    input wire logic carr_at_lower_i, // carriage current at lower limit
    output logic switched_drive_supply_o, // drive supply enabled
    output logic [2:0] phase_supply_on_o, // phase supply switch on
    output logic [2:0] phase_slow_path_o, // slow decay switch on
    output logic step_ref_high_o, // 3.0A reference, else 1.0A
    output logic carr_fwd_pair_o, // forward transistor pair
    output logic carr_rev_pair_o, // reverse transistor pair
    output logic carr_chop_on_o, // carriage chopper on
    output logic carr_ref_high_o // 2.86A reference, else 1.43A
);
    import motor_pkg::*;

    // ==========================================================
    // pin synchronisers; first stage feeds only the second
    logic [8:0] sync1_reg, sync2_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {power_good_i, carr_at_lower_i, carr_at_upper_i, phase_at_lower_i, phase_at_upper_i};
            sync2_reg <= sync1_reg;
        end
    end

    logic pwr;
    assign pwr = sync2_reg[8];

    // ==========================================================
    // per-phase chopper and decay path
    // the hysteresis band is analog; here the flop just remembers the side
    logic [2:0] chop_reg, chop_next, slow_reg, slow_next;
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_phase
            always_comb begin
                chop_next[i] = pwr && !link.phase_sel_n[i] && !sync2_reg[i]
                               && (sync2_reg[3 + i] || chop_reg[i]); // R8
                slow_next[i] = pwr && (!link.phase_sel_n[i] || link.fast_decay_n); // R4
            end
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    chop_reg[i] <= 1'b0;
                    slow_reg[i] <= 1'b0;
                end else begin
                    chop_reg[i] <= chop_next[i];
                    slow_reg[i] <= slow_next[i];
                end
            end
        end
    endgenerate

    // ==========================================================
    // carriage bridge and references; power good gates every switch
    logic carr_on, fwd_next, rev_next, cchop_next, cref_next, sref_next;
    logic fwd_reg, rev_reg, cchop_reg, cref_reg, sref_reg, supply_reg;
    always_comb begin
        carr_on = pwr && !link.carriage_current_on_n; // R16 R17
        fwd_next = carr_on && !link.carriage_dir_fwd_n; // R19
        rev_next = carr_on && link.carriage_dir_fwd_n; // R14
        cchop_next = carr_on && !sync2_reg[6] && (sync2_reg[7] || cchop_reg);
        cref_next = !link.carriage_high_current_n; // R15 R18
        sref_next = !link.step_current_sel_n; // R3
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fwd_reg <= 1'b0;
            rev_reg <= 1'b0;
            cchop_reg <= 1'b0;
            cref_reg <= 1'b0;
            sref_reg <= 1'b0;
            supply_reg <= 1'b0;
        end else begin
            fwd_reg <= fwd_next;
            rev_reg <= rev_next;
            cchop_reg <= cchop_next;
            cref_reg <= cref_next;
            sref_reg <= sref_next;
            supply_reg <= pwr; // R16
        end
    end

    assign switched_drive_supply_o = supply_reg;
    assign phase_supply_on_o = chop_reg;
    assign phase_slow_path_o = slow_reg;
    assign step_ref_high_o = sref_reg;
    assign carr_fwd_pair_o = fwd_reg;
    assign carr_rev_pair_o = rev_reg;
    assign carr_chop_on_o = cchop_reg;
    assign carr_ref_high_o = cref_reg;
endmodule
`default_nettype wire

// >>> motor_link_monitor.sv
/* checker on the controller-to-driver motor lines.
   assumes it sits beside the link interface, on the controller clock. */
`timescale 1ns/1ps
`default_nettype none
module motor_link_monitor #(
    parameter int unsigned STEP_CYCLES = motor_pkg::STEP_CYCLES  // step length
) (
    input wire logic clk_i, // logic clock
    input wire logic rst_i, // async reset, high
    input wire logic [2:0] phase_sel_n, // phase selects
    input wire logic step_current_sel_n, // step current select
    input wire logic fast_decay_n // fast decay select
);
    import motor_pkg::*;
    // ==========================================================
    // counters: cycles since the last phase change, cycles in fast decay
    logic [31:0] gap_reg, gap_next, fast_reg, fast_next;
    logic [2:0] prev_reg;
    always_comb begin
        gap_next = (phase_sel_n != prev_reg) ? 32'h0 : gap_reg + 32'h1;
        fast_next = fast_decay_n ? 32'h0 : fast_reg + 32'h1;
    end
    // prev_reg starts at phase a so the first release shows no change
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_reg <= 32'h0;
            fast_reg <= 32'h0;
            prev_reg <= PHASE_A_N;
        end else begin
            gap_reg <= gap_next;
            fast_reg <= fast_next;
            prev_reg <= phase_sel_n;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_phase_one_hot: assert property ($onehot(~phase_sel_n)) else $error("phase selects not exclusive");
    a_phase_rotates: assert property (phase_sel_n != prev_reg |-> phase_sel_n == {prev_reg[1:0], prev_reg[2]}
        || phase_sel_n == {prev_reg[0], prev_reg[2:1]}) else $error("phase order broken");
    a_hold_slow_decay: assert property (step_current_sel_n |-> fast_decay_n) else $error("fast decay in hold");
    a_fast_on_advance: assert property ($fell(fast_decay_n) |-> phase_sel_n != prev_reg
        && !step_current_sel_n) else $error("fast decay off step boundary");
    a_decay_window: assert property ($rose(fast_decay_n) |-> fast_reg == DECAY_CYCLES) else $error("decay width");
    a_step_spacing: assert property (phase_sel_n != prev_reg && !step_current_sel_n && !$past(step_current_sel_n)
        |-> gap_reg == STEP_CYCLES - 1) else $error("step length wrong");
    a_hold_after_feed: assert property ($rose(step_current_sel_n) |-> gap_reg == STEP_CYCLES - 1
        && fast_decay_n) else $error("hold not one step after last advance");
    a_reset_phase_a: assert property ($fell(rst_i) |-> phase_sel_n == PHASE_A_N
        && step_current_sel_n) else $error("power-on phase wrong");
    cover property ($rose(step_current_sel_n));
    cover property ($fell(fast_decay_n));
    cover property (phase_sel_n != prev_reg && step_current_sel_n);
endmodule
`default_nettype wire

// >>> printer_motor_drive_control_tb.sv
/* testbench joining controller and driver over the link.
   assumes motor_pkg, the link interface and the monitor compile first. */
`timescale 1ns/1ps
`default_nettype none
module printer_motor_drive_control_tb;
    import motor_pkg::*;
    localparam int S = 4100;
    localparam int LIMIT = 60000;
    logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, arv = 0, pg = 0, clo = 1;
    logic [3:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rd;
    logic [2:0] up = 0, lo = 3'h7, pon, slow;
    logic awr, wr, bv, arr, rv, sup, fwd, rev, chop, crh, srh;
    logic [1:0] bresp, rresp;
    int fails = 0, n_checks = 0, cyc = 0;
    motor_link_if link ();
    motor_controller #(.STEP_CYCLES(S)) i_motor_controller (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(aa), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(1'b1), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ra), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .s_axi_rdata_o(rd),
        .s_axi_rresp_o(rresp), .link(link.ctrl));
    motor_driver i_motor_driver (.clk_i(clk_i), .rst_i(rst_i), .link(link.drv), .power_good_i(pg),
        .phase_at_upper_i(up), .phase_at_lower_i(lo), .carr_at_upper_i(1'b0), .carr_at_lower_i(clo),
        .switched_drive_supply_o(sup), .phase_supply_on_o(pon), .phase_slow_path_o(slow),
        .step_ref_high_o(srh), .carr_fwd_pair_o(fwd), .carr_rev_pair_o(rev), .carr_chop_on_o(chop),
        .carr_ref_high_o(crh));
    motor_link_monitor #(.STEP_CYCLES(S)) i_motor_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
        .phase_sel_n(link.phase_sel_n), .step_current_sel_n(link.step_current_sel_n),
        .fast_decay_n(link.fast_decay_n));
    // ==========================================================
    // clock and hang guard
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // bready and rready stay high, so a valid seen at an edge is a handshake
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
        awv <= 1; wv <= 1; aa <= a; wd <= d;
        do begin
            @(posedge clk_i);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!bv);
        chk({30'h0, bresp}, {30'h0, rsp});
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
        arv <= 1; ra <= a;
        do @(posedge clk_i); while (!arr);
        arv <= 0;
        do @(posedge clk_i); while (!rv);
        chk(rd, d);
        chk({30'h0, rresp}, {30'h0, rsp});
    endtask
    task automatic t_reset_power;
        chk({link.phase_sel_n, link.step_current_sel_n, link.fast_decay_n}, {PHASE_A_N, 2'b11});
        rd_reg(ADDR_STATUS, {25'h0, PHASE_A_N, 4'h0}, RESP_OKAY);
        rd_reg(4'hc, 32'h0, RESP_SLVERR);
        wr_reg(4'hc, 32'h1, RESP_SLVERR);
        chk({sup, pon}, 4'h0);
        pg <= 1;
        repeat (5) @(posedge clk_i);
        chk({sup, pon}, 4'h9);
        up <= 3'h1;
        repeat (5) @(posedge clk_i);
        chk(pon, 3'h0);
        up <= 3'h0;
    endtask
    task automatic t_carriage;
        wr_reg(ADDR_CTRL, 32'h7, RESP_OKAY);
        chk({link.carriage_current_on_n, link.carriage_high_current_n, link.carriage_dir_fwd_n}, 3'h1);
        repeat (5) @(posedge clk_i);
        chk({fwd, rev, chop, crh}, 4'h7);
        wr_reg(ADDR_CTRL, 32'h1, RESP_OKAY);
        repeat (5) @(posedge clk_i);
        chk({fwd, rev, chop, crh}, 4'ha);
        wr_reg(ADDR_CTRL, 32'h0, RESP_OKAY);
        chk({link.carriage_current_on_n, link.carriage_high_current_n, link.carriage_dir_fwd_n}, 3'h6);
        repeat (5) @(posedge clk_i);
        chk({chop, crh}, 2'h0);
    endtask
    task automatic t_feed;
        logic [2:0] ph;
        int n = 0;
        ph = link.phase_sel_n;
        wr_reg(ADDR_FEED, 32'h1, RESP_OKAY);
        for (int i = 0; i < 12 * S + 8; i++) begin
            if (link.phase_sel_n !== ph) begin
                n++;
                chk(link.phase_sel_n, {ph[1:0], ph[2]});
                chk(link.fast_decay_n, n == 12);
                ph = link.phase_sel_n;
            end
            if (i == 8) chk({srh, slow}, 4'ha);
            @(posedge clk_i);
        end
        chk(n, 12);
        chk({link.step_current_sel_n, srh, slow}, 5'h17);
        rd_reg(ADDR_STATUS, {25'h0, PHASE_A_N, 4'h0}, RESP_OKAY);
    endtask
    task automatic t_align;
        logic [2:0] ph;
        ph = link.phase_sel_n;
        wr_reg(ADDR_CTRL, 32'h8, RESP_OKAY);
        wr_reg(ADDR_FEED, 32'h100, RESP_OKAY);
        chk({link.phase_sel_n, link.step_current_sel_n}, {ph[0], ph[2:1], 1'b1});
        wr_reg(ADDR_CTRL, 32'h0, RESP_OKAY);
        wr_reg(ADDR_FEED, 32'h100, RESP_OKAY);
        chk(link.phase_sel_n, ph);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        t_reset_power;
        t_carriage;
        t_feed;
        t_align;
        finish_test;
    end
endmodule
`default_nettype wire
